// ==== core/bfe_core.sv ====
`timescale 1ns/1ps
module bfe_core
  import bfe_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output logic             rx_ready_ff,
  output logic      [7:0]  tx_data_ff,
  output logic             tx_valid_ff,
  input  wire logic        tx_ready,
  output logic             mem_rd_ff,
  output logic             mem_area_ff,
  output logic      [31:0] mem_addr_ff,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_rvalid,
  output logic             load_req_ff,
  input  wire logic        load_done,
  input  wire logic        load_fail,
  output logic             erase_req_ff,
  output logic      [7:0]  erase_blk_ff,
  input  wire logic        erase_done,
  input  wire logic        erase_fail
);
  // ***********************************************************
  // State
  // ***********************************************************
  bfe_state_t  state_ff, nxt_state;
  logic [7:0]  cmd_ff, nxt_cmd;
  logic [7:0]  len_ff, nxt_len;
  logic [7:0]  cnt_ff, nxt_cnt;
  logic [79:0] body_ff, nxt_body;
  logic [7:0]  buf_ff [BUF_DEPTH], nxt_buf [BUF_DEPTH];
  logic [2:0]  rlen_ff, nxt_rlen;
  logic [2:0]  idx_ff, nxt_idx;
  logic [1:0]  tail_ff, nxt_tail;
  logic [7:0]  txsum_ff, nxt_txsum;
  logic [31:0] rem_ff, nxt_rem;
  logic [31:0] acc_ff, nxt_acc;
  logic        blank_ff, nxt_blank;
  logic        scan_blank_ff, nxt_scan_blank;
  logic        wait_ff, nxt_wait;
  logic        erase_sel_ff, nxt_erase_sel;
  logic        err_ff, nxt_err;
  logic        nxt_rx_ready, nxt_tx_valid, nxt_mem_rd, nxt_area;
  logic        nxt_load_req, nxt_erase_req;
  logic [7:0]  nxt_tx_data, nxt_erase_blk;
  logic [31:0] nxt_addr;
  logic [7:0]  rx_sum;
  logic        take, sum_start, sum_add;
  logic [7:0]  f_area, f_blk;
  logic [31:0] f_addr, f_count, a_base, a_size;
  logic [32:0] f_end, a_end;

  assign take      = rx_valid && rx_ready_ff;
  assign sum_start = take && (state_ff == S_IDLE);
  assign sum_add   = take && (state_ff != S_IDLE);

  // ***********************************************************
  // Received frame fields
  // ***********************************************************
  // MSB-first field unpack
  assign f_area  = body_ff[79:72];
  assign f_addr  = body_ff[71:40];
  assign f_count = body_ff[39:8];
  assign f_blk   = body_ff[15:8];
  assign a_base  = (f_area == AREA_BOOT) ? BOOT_BASE : MAIN_BASE;
  assign a_size  = (f_area == AREA_BOOT) ? BOOT_SIZE : MAIN_SIZE;
  assign f_end   = {1'b0, f_addr} + {1'b0, f_count};
  assign a_end   = {1'b0, a_base} + {1'b0, a_size};

  // running sum of the received frame
  bfe_sum8 u_rx_sum (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .start   (sum_start),
    .add     (sum_add),
    .data    (rx_data),
    .sum_ff  (rx_sum)
  );

  // ***********************************************************
  // Sequencer next state
  // ***********************************************************
  always_comb begin
    nxt_state      = state_ff;
    nxt_cmd        = cmd_ff;
    nxt_len        = len_ff;
    nxt_cnt        = cnt_ff;
    nxt_body       = body_ff;
    nxt_buf        = buf_ff;
    nxt_rlen       = rlen_ff;
    nxt_idx        = idx_ff;
    nxt_tail       = tail_ff;
    nxt_txsum      = txsum_ff;
    nxt_rem        = rem_ff;
    nxt_acc        = acc_ff;
    nxt_blank      = blank_ff;
    nxt_scan_blank = scan_blank_ff;
    nxt_wait       = wait_ff;
    nxt_erase_sel  = erase_sel_ff;
    nxt_err        = err_ff;
    nxt_tx_data    = tx_data_ff;
    nxt_tx_valid   = tx_valid_ff;
    nxt_mem_rd     = 1'b0;
    nxt_area       = mem_area_ff;
    nxt_addr       = mem_addr_ff;
    nxt_load_req   = 1'b0;
    nxt_erase_req  = 1'b0;
    nxt_erase_blk  = erase_blk_ff;
    case (state_ff)
      S_IDLE: begin
        if (take) begin
          nxt_cmd = rx_data;
          // erase and read frames carry a length
          if (rx_data == CMD_BLK_ERASE || rx_data == CMD_MEM_READ) begin
            nxt_state = S_RXLEN;
          end else begin
            nxt_state = S_EXEC;
          end
        end
      end
      S_RXLEN: begin
        if (take) begin
          nxt_len   = rx_data;
          nxt_cnt   = 8'h00;
          nxt_state = S_RXBODY;
        end
      end
      S_RXBODY: begin
        // Shift keeps the last ten bytes; the final one is the checksum
        if (take) begin
          nxt_body = {body_ff[71:0], rx_data};
          nxt_cnt  = cnt_ff + 8'h01;
          if (cnt_ff == len_ff) begin
            nxt_state = S_EXEC;
          end
        end
      end
      S_EXEC: begin
        // Default answer is a two-byte error; branches override it
        nxt_state  = S_SEND;
        nxt_idx    = 3'h0;
        nxt_txsum  = 8'h00;
        nxt_tail   = TAIL_NONE;
        nxt_rlen   = 3'h2;
        nxt_buf[1] = ERR_SUM;
        case (cmd_ff)
          CMD_ERASE_SEL: begin
            nxt_load_req = 1'b1;
            nxt_state    = S_LOAD;
          end
          CMD_BLK_ERASE: begin
            nxt_buf[0] = RSP_BLK_ERASE;
            if (rx_sum != 8'h00) begin
              nxt_buf[1] = ERR_SUM;
            end else if (len_ff != LEN_BLK_ERASE || !erase_sel_ff) begin
              nxt_buf[1] = ERR_COMMAND;
            end else if (f_blk == BLK_STOP) begin
              nxt_erase_sel = 1'b0;
              nxt_buf[0]    = RSP_ACK;
              nxt_rlen      = 3'h1;
            end else if (f_blk >= NUM_BLOCKS) begin
              nxt_buf[1] = ERR_BLOCK;
            end else begin
              // erase acts on the main area only
              nxt_erase_req = 1'b1;
              nxt_erase_blk = f_blk;
              nxt_state     = S_ERASE;
            end
          end
          CMD_MEM_READ: begin
            nxt_buf[0] = RSP_MEM_READ;
            if (rx_sum != 8'h00) begin
              nxt_buf[1] = ERR_SUM;
            end else if (len_ff != LEN_MEM_READ) begin
              nxt_buf[1] = ERR_SIZE;
            end else if (f_area != AREA_BOOT && f_area != AREA_MAIN) begin
              nxt_buf[1] = ERR_ADDR;
            end else if (f_addr < a_base || {1'b0, f_addr} >= a_end) begin
              nxt_buf[1] = ERR_ADDR;
            end else if (f_end > a_end) begin
              nxt_buf[1] = ERR_SIZE;
            end else begin
              nxt_buf[0] = CMD_MEM_READ;
              nxt_buf[1] = f_count[31:24];
              nxt_buf[2] = f_count[23:16];
              nxt_buf[3] = f_count[15:8];
              nxt_buf[4] = f_count[7:0];
              nxt_rlen   = 3'h5;
              nxt_tail   = TAIL_DATA;
              nxt_area   = (f_area == AREA_MAIN);
              nxt_addr   = f_addr;
              nxt_rem    = f_count;
              nxt_wait   = 1'b0;
            end
          end
          CMD_SUM_BOOT, CMD_SUM_MAIN, CMD_BLANK_BOOT, CMD_BLANK_MAIN: begin
            // Low bit of the command picks boot (0) or main (1)
            nxt_area       = cmd_ff[0];
            nxt_addr       = cmd_ff[0] ? MAIN_BASE : BOOT_BASE;
            nxt_rem        = cmd_ff[0] ? MAIN_SIZE : BOOT_SIZE;
            nxt_acc        = 32'h0000_0000;
            nxt_blank      = 1'b1;
            nxt_scan_blank = (cmd_ff == CMD_BLANK_BOOT || cmd_ff == CMD_BLANK_MAIN);
            nxt_wait       = 1'b0;
            nxt_state      = S_SCAN;
          end
          CMD_STATE_INQ: begin
            nxt_buf[0] = RSP_STATE_INQ;
            nxt_buf[1] = LEN_STATE;
            nxt_buf[2] = erase_sel_ff ? ST_BLK_WAIT : ST_SEL_WAIT;
            nxt_buf[3] = err_ff ? ERRFLAG_SET : ERRFLAG_OK;
            nxt_rlen   = 3'h4;
            nxt_tail   = TAIL_SUM;
          end
          default: begin
            nxt_buf[0] = ERR_COMMAND;
            nxt_rlen   = 3'h1;
          end
        endcase
      end
      S_LOAD: begin
        nxt_state  = S_SEND;
        nxt_idx    = 3'h0;
        nxt_tail   = TAIL_NONE;
        if (load_done) begin
          nxt_erase_sel = 1'b1;
          nxt_buf[0]    = RSP_ACK;
          nxt_rlen      = 3'h1;
        end else if (load_fail) begin
          nxt_buf[0] = RSP_ERASE_SEL;
          nxt_buf[1] = ERR_SELECT;
          nxt_rlen   = 3'h2;
        end else begin
          nxt_state = S_LOAD;
        end
      end
      S_ERASE: begin
        nxt_state  = S_SEND;
        nxt_idx    = 3'h0;
        nxt_tail   = TAIL_NONE;
        if (erase_done) begin
          nxt_buf[0] = RSP_ACK;
          nxt_rlen   = 3'h1;
        end else if (erase_fail) begin
          nxt_buf[0] = RSP_BLK_ERASE;
          nxt_buf[1] = ERR_ERASE;
          nxt_rlen   = 3'h2;
        end else begin
          nxt_state = S_ERASE;
        end
      end
      S_SCAN: begin
        // One outstanding read at a time; flash latency is free
        if (rem_ff == 32'h0000_0000) begin
          nxt_state = S_SEND;
          nxt_idx   = 3'h0;
          nxt_txsum = 8'h00;
          if (scan_blank_ff) begin
            nxt_buf[0] = RSP_ACK;
            nxt_buf[1] = ERR_ERASE_INC;
            nxt_rlen   = 3'h1;
            nxt_tail   = TAIL_NONE;
            if (!blank_ff) begin
              nxt_buf[0] = mem_area_ff ? RSP_BLANK_MAIN : RSP_BLANK_BOOT;
              nxt_rlen   = 3'h2;
            end
          end else begin
            nxt_buf[0] = mem_area_ff ? RSP_SUM_MAIN : RSP_SUM_BOOT;
            nxt_buf[1] = LEN_SUM;
            nxt_buf[2] = acc_ff[31:24];
            nxt_buf[3] = acc_ff[23:16];
            nxt_buf[4] = acc_ff[15:8];
            nxt_rlen   = 3'h5;
            nxt_tail   = TAIL_SUM;
          end
        end else if (!wait_ff) begin
          nxt_mem_rd = 1'b1;
          nxt_wait   = 1'b1;
        end else if (mem_rvalid) begin
          nxt_acc   = acc_ff + {24'h00_0000, mem_rdata};
          nxt_blank = blank_ff && (mem_rdata == BLANK_BYTE);
          nxt_rem   = rem_ff - 32'h0000_0001;
          nxt_addr  = mem_addr_ff + 32'h0000_0001;
          nxt_wait  = 1'b0;
        end
      end
      S_SEND: begin
        // Fourth (low) sum byte cannot fit the buffer, so it rides as a send tail
        if (!tx_valid_ff) begin
          nxt_tx_data  = buf_ff[idx_ff];
          nxt_tx_valid = 1'b1;
          nxt_txsum    = txsum_ff + buf_ff[idx_ff];
          // Only plain replies can be errors; a sum tail byte may have bit 7 set
          if (tail_ff == TAIL_NONE && buf_ff[0] != RSP_ACK && buf_ff[0][7]) begin
            nxt_err = 1'b1;
          end
        end else if (tx_ready) begin
          nxt_tx_valid = 1'b0;
          nxt_idx      = idx_ff + 3'h1;
          if (idx_ff + 3'h1 == rlen_ff) begin
            if (tail_ff == TAIL_DATA) begin
              nxt_state = S_RDATA;
            end else if (tail_ff == TAIL_SUM) begin
              nxt_state = S_RSUM;
            end else begin
              nxt_state = S_IDLE;
            end
            if (tail_ff == TAIL_SUM && rlen_ff == 3'h5 && !scan_blank_ff) begin
              nxt_buf[0] = acc_ff[7:0];
              nxt_rlen   = 3'h1;
              nxt_idx    = 3'h0;
              nxt_tail   = TAIL_SUM;
              nxt_state  = S_SEND;
              nxt_acc    = 32'h0000_0000;
              nxt_scan_blank = 1'b1;
            end
          end
        end
      end
      S_RDATA: begin
        if (tx_valid_ff) begin
          if (tx_ready) begin
            nxt_tx_valid = 1'b0;
            nxt_wait     = 1'b0;
          end
        end else if (rem_ff == 32'h0000_0000) begin
          nxt_state = S_RSUM;
        end else if (!wait_ff) begin
          nxt_mem_rd = 1'b1;
          nxt_wait   = 1'b1;
        end else if (mem_rvalid) begin
          nxt_tx_data  = mem_rdata;
          nxt_tx_valid = 1'b1;
          nxt_txsum    = txsum_ff + mem_rdata;
          nxt_rem      = rem_ff - 32'h0000_0001;
          nxt_addr     = mem_addr_ff + 32'h0000_0001;
        end
      end
      S_RSUM: begin
        // closing byte makes the reply sum to zero
        if (!tx_valid_ff) begin
          nxt_tx_data  = 8'h00 - txsum_ff;
          nxt_tx_valid = 1'b1;
        end else if (tx_ready) begin
          nxt_tx_valid = 1'b0;
          nxt_state    = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
    // accept bytes only while collecting a command
    nxt_rx_ready = (nxt_state == S_IDLE) || (nxt_state == S_RXLEN) ||
                   (nxt_state == S_RXBODY);
  end

  // ***********************************************************
  // Registers
  // ***********************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff      <= S_IDLE;
      cmd_ff        <= 8'h00;
      len_ff        <= 8'h00;
      cnt_ff        <= 8'h00;
      body_ff       <= '0;
      buf_ff        <= '{default: 8'h00};
      rlen_ff       <= 3'h0;
      idx_ff        <= 3'h0;
      tail_ff       <= TAIL_NONE;
      txsum_ff      <= 8'h00;
      rem_ff        <= 32'h0000_0000;
      acc_ff        <= 32'h0000_0000;
      blank_ff      <= 1'b1;
      scan_blank_ff <= 1'b0;
      wait_ff       <= 1'b0;
      erase_sel_ff  <= 1'b0;
      err_ff        <= 1'b0;
      rx_ready_ff   <= 1'b0;
      tx_data_ff    <= 8'h00;
      tx_valid_ff   <= 1'b0;
      mem_rd_ff     <= 1'b0;
      mem_area_ff   <= 1'b0;
      mem_addr_ff   <= 32'h0000_0000;
      load_req_ff   <= 1'b0;
      erase_req_ff  <= 1'b0;
      erase_blk_ff  <= 8'h00;
    end else begin
      state_ff      <= nxt_state;
      cmd_ff        <= nxt_cmd;
      len_ff        <= nxt_len;
      cnt_ff        <= nxt_cnt;
      body_ff       <= nxt_body;
      buf_ff        <= nxt_buf;
      rlen_ff       <= nxt_rlen;
      idx_ff        <= nxt_idx;
      tail_ff       <= nxt_tail;
      txsum_ff      <= nxt_txsum;
      rem_ff        <= nxt_rem;
      acc_ff        <= nxt_acc;
      blank_ff      <= nxt_blank;
      scan_blank_ff <= nxt_scan_blank;
      wait_ff       <= nxt_wait;
      erase_sel_ff  <= nxt_erase_sel;
      err_ff        <= nxt_err;
      rx_ready_ff   <= nxt_rx_ready;
      tx_data_ff    <= nxt_tx_data;
      tx_valid_ff   <= nxt_tx_valid;
      mem_rd_ff     <= nxt_mem_rd;
      mem_area_ff   <= nxt_area;
      mem_addr_ff   <= nxt_addr;
      load_req_ff   <= nxt_load_req;
      erase_req_ff  <= nxt_erase_req;
      erase_blk_ff  <= nxt_erase_blk;
    end
  end
endmodule // bfe_core

// ==== core/bfe_pkg.sv ====
package bfe_pkg;
  // ***********************************************************
  // Command and response codes
  // ***********************************************************
  localparam logic [7:0] CMD_ERASE_SEL  = 8'h48;
  localparam logic [7:0] CMD_BLK_ERASE  = 8'h58;
  localparam logic [7:0] CMD_MEM_READ   = 8'h52;
  localparam logic [7:0] CMD_SUM_BOOT   = 8'h4a;
  localparam logic [7:0] CMD_SUM_MAIN   = 8'h4b;
  localparam logic [7:0] CMD_BLANK_BOOT = 8'h4c;
  localparam logic [7:0] CMD_BLANK_MAIN = 8'h4d;
  localparam logic [7:0] CMD_STATE_INQ  = 8'h4f;
  localparam logic [7:0] RSP_ACK        = 8'h06;
  localparam logic [7:0] RSP_ERASE_SEL  = 8'hc8;
  localparam logic [7:0] RSP_BLK_ERASE  = 8'hd8;
  localparam logic [7:0] RSP_MEM_READ   = 8'hd2;
  localparam logic [7:0] RSP_BLANK_BOOT = 8'hcc;
  localparam logic [7:0] RSP_BLANK_MAIN = 8'hcd;
  localparam logic [7:0] RSP_SUM_BOOT   = 8'h5a;
  localparam logic [7:0] RSP_SUM_MAIN   = 8'h5b;
  localparam logic [7:0] RSP_STATE_INQ  = 8'h5f;
  // ***********************************************************
  // Frame layout
  // ***********************************************************
  localparam logic [7:0] LEN_BLK_ERASE  = 8'h01;
  localparam logic [7:0] LEN_MEM_READ   = 8'h09;
  localparam logic [7:0] LEN_SUM        = 8'h04;
  localparam logic [7:0] LEN_STATE      = 8'h02;
  localparam logic [7:0] BLK_STOP       = 8'hff;
  localparam logic [7:0] AREA_BOOT      = 8'h00;
  localparam logic [7:0] AREA_MAIN      = 8'h01;
  localparam logic [7:0] BLANK_BYTE     = 8'hff;
  // ***********************************************************
  // Error and status codes
  // ***********************************************************
  localparam logic [7:0] ERR_NONE       = 8'h00;
  localparam logic [7:0] ERR_SUM        = 8'h11;
  localparam logic [7:0] ERR_DEV_CODE   = 8'h21;
  localparam logic [7:0] ERR_BLOCK      = 8'h29;
  localparam logic [7:0] ERR_ADDR       = 8'h2a;
  localparam logic [7:0] ERR_SIZE       = 8'h2b;
  localparam logic [7:0] ERR_ERASE      = 8'h51;
  localparam logic [7:0] ERR_ERASE_INC  = 8'h52;
  localparam logic [7:0] ERR_SELECT     = 8'h54;
  localparam logic [7:0] ERR_COMMAND    = 8'h80;
  localparam logic [7:0] ERR_BITRATE    = 8'hff;
  localparam logic [7:0] ST_DEV_SEL     = 8'h11;
  localparam logic [7:0] ST_CLK_SEL     = 8'h12;
  localparam logic [7:0] ST_RATE_SEL    = 8'h13;
  localparam logic [7:0] ST_PE_TRANS    = 8'h1f;
  localparam logic [7:0] ST_PROG_ERASE  = 8'h31;
  localparam logic [7:0] ST_SEL_WAIT    = 8'h3f;
  localparam logic [7:0] ST_PROG_WAIT   = 8'h4f;
  localparam logic [7:0] ST_BLK_WAIT    = 8'h5f;
  localparam logic [7:0] ERRFLAG_OK     = 8'h00;
  localparam logic [7:0] ERRFLAG_SET    = 8'h01;
  // ***********************************************************
  // Flash geometry
  // ***********************************************************
  localparam logic [31:0] BOOT_BASE     = 32'h0000_0000;
  localparam logic [31:0] BOOT_SIZE     = 32'h0000_2000;
  localparam logic [31:0] MAIN_BASE     = 32'h0000_0000;
  localparam logic [31:0] MAIN_SIZE     = 32'h0008_0000;
  localparam logic [7:0]  NUM_BLOCKS    = 8'h0c;
  // ***********************************************************
  // Response tail kinds, buffer depth and sequencer states
  // ***********************************************************
  localparam logic [1:0] TAIL_NONE      = 2'h0;
  localparam logic [1:0] TAIL_SUM       = 2'h1;
  localparam logic [1:0] TAIL_DATA      = 2'h2;
  localparam int         BUF_DEPTH      = 5;
  typedef enum logic [3:0] {
    S_IDLE   = 4'h0,
    S_RXLEN  = 4'h1,
    S_RXBODY = 4'h3,
    S_EXEC   = 4'h2,
    S_LOAD   = 4'h6,
    S_ERASE  = 4'h7,
    S_SCAN   = 4'h5,
    S_SEND   = 4'h4,
    S_RDATA  = 4'hc,
    S_RSUM   = 4'hd
  } bfe_state_t;
endpackage

// ==== core/bfe_sum8.sv ====
`timescale 1ns/1ps
// ***********************************************************
// Running 8-bit sum of received frame bytes
// ***********************************************************
module bfe_sum8
  import bfe_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       start,
  input  wire logic       add,
  input  wire logic [7:0] data,
  output logic      [7:0] sum_ff
);
  logic [7:0] nxt_sum;

  // Start reloads with the first byte so no separate clear cycle is needed
  always_comb begin
    nxt_sum = sum_ff;
    if (start) begin
      nxt_sum = data;
    end else if (add) begin
      nxt_sum = sum_ff + data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sum_ff <= 8'h00;
    end else begin
      sum_ff <= nxt_sum;
    end
  end
endmodule // bfe_sum8

// ==== test/bfe_core_assertions.sv ====
`timescale 1ns/1ps
module bfe_core_chk
  import bfe_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       rx_ready_ff,
  input wire logic [7:0] tx_data_ff,
  input wire logic       tx_valid_ff,
  input wire logic       tx_ready,
  input wire logic       mem_rd_ff,
  input wire logic       load_req_ff,
  input wire logic       load_done,
  input wire logic       load_fail,
  input wire logic       erase_req_ff,
  input wire logic [7:0] erase_blk_ff,
  input wire logic       erase_done,
  input wire logic       erase_fail
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Reply and request timing against the serial side
  busy_rx_a: assert property (tx_valid_ff |-> !rx_ready_ff) else $error("rx open in reply");
  tx_hold_a: assert property (tx_valid_ff && !tx_ready |=> tx_valid_ff && $stable(tx_data_ff))
    else $error("tx byte dropped");
  load_ack_a: assert property (load_done |-> ##[1:6] tx_valid_ff && tx_data_ff == 8'h06)
    else $error("no load ack");
  load_err_a: assert property (load_fail |-> ##[1:6] tx_valid_ff && tx_data_ff == 8'hc8)
    else $error("no load error");
  erase_ack_a: assert property (erase_done |-> ##[1:6] tx_valid_ff && tx_data_ff == 8'h06)
    else $error("no erase ack");
  erase_err_a: assert property (erase_fail |-> ##[1:6] tx_valid_ff && tx_data_ff == 8'hd8)
    else $error("no erase error");
  blk_range_a: assert property (erase_req_ff |-> erase_blk_ff < NUM_BLOCKS && !tx_valid_ff)
    else $error("bad erase block");
  load_once_a: assert property (load_req_ff |=> !load_req_ff [*3])
    else $error("load repeated");
  rd_pulse_a: assert property (mem_rd_ff |=> !mem_rd_ff) else $error("read not a pulse");
  cover property (load_fail);
  cover property (erase_fail);
  cover property (mem_rd_ff);
endmodule // bfe_core_chk

bind bfe_core bfe_core_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .rx_ready_ff(rx_ready_ff),
  .tx_data_ff(tx_data_ff), .tx_valid_ff(tx_valid_ff), .tx_ready(tx_ready),
  .mem_rd_ff(mem_rd_ff), .load_req_ff(load_req_ff), .load_done(load_done),
  .load_fail(load_fail), .erase_req_ff(erase_req_ff), .erase_blk_ff(erase_blk_ff),
  .erase_done(erase_done), .erase_fail(erase_fail));

// ==== test/bfe_flash_model.sv ====
`timescale 1ns/1ps
module bfe_flash_model (
  input  wire logic        sys_clk,
  input  wire logic        fail,
  input  wire logic        mem_rd_ff,
  input  wire logic        mem_area_ff,
  input  wire logic [31:0] mem_addr_ff,
  input  wire logic        load_req_ff,
  input  wire logic        erase_req_ff,
  output logic      [7:0]  mem_rdata,
  output logic             mem_rvalid,
  output logic             load_done,
  output logic             load_fail,
  output logic             erase_done,
  output logic             erase_fail
);
  initial {mem_rdata, mem_rvalid, load_done, load_fail, erase_done, erase_fail} = '0;
  // One-cycle answers; idle data flips so a stale byte never passes
  always @(negedge sys_clk) begin
    mem_rvalid <= mem_rd_ff;
    mem_rdata  <= mem_rd_ff ? (mem_addr_ff[7:0] ^ {7'h0, mem_area_ff}) : ~mem_rdata;
    load_done  <= load_req_ff && !fail;
    load_fail  <= load_req_ff && fail;
    erase_done <= erase_req_ff && !fail;
    erase_fail <= erase_req_ff && fail;
  end
endmodule // bfe_flash_model

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk, rst_b, rx_valid, tx_ready, fail, rx_ready_ff, tx_valid_ff, mem_rd_ff;
  logic        mem_area_ff, mem_rvalid, load_req_ff, load_done, load_fail;
  logic        erase_req_ff, erase_done, erase_fail;
  logic [7:0]  rx_data, tx_data_ff, mem_rdata, erase_blk_ff;
  logic [31:0] mem_addr_ff;
  int          num_errors, cmp_count;
  bfe_core uut (.sys_clk(sys_clk), .rst_b(rst_b), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready_ff(rx_ready_ff), .tx_data_ff(tx_data_ff), .tx_valid_ff(tx_valid_ff),
    .tx_ready(tx_ready), .mem_rd_ff(mem_rd_ff), .mem_area_ff(mem_area_ff),
    .mem_addr_ff(mem_addr_ff), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
    .load_req_ff(load_req_ff), .load_done(load_done), .load_fail(load_fail),
    .erase_req_ff(erase_req_ff), .erase_blk_ff(erase_blk_ff), .erase_done(erase_done),
    .erase_fail(erase_fail));
  bfe_flash_model u_flash (.sys_clk(sys_clk), .fail(fail), .mem_rd_ff(mem_rd_ff),
    .mem_area_ff(mem_area_ff), .mem_addr_ff(mem_addr_ff), .load_req_ff(load_req_ff),
    .erase_req_ff(erase_req_ff), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
    .load_done(load_done), .load_fail(load_fail), .erase_done(erase_done),
    .erase_fail(erase_fail));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic end_of_test();
    $display("Compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One byte in; waits for the receiver to reopen after a reply
  task automatic send(input logic [7:0] b);
    @(negedge sys_clk);
    while (rx_ready_ff !== 1'b1) @(negedge sys_clk);
    rx_data = b;
    rx_valid = 1'b1;
    @(negedge sys_clk);
    rx_valid = 1'b0;
  endtask
  // Frame with zero-sum trailer; a nonzero bad skews it on purpose
  task automatic frame(input logic [7:0] q[$], input logic [7:0] bad);
    foreach (q[i]) send(q[i]);
    send(bad - q.sum());
  endtask
  task automatic rd(input logic [7:0] ar, input logic [31:0] a, input logic [31:0] c);
    frame('{8'h52, 8'h09, ar, a[31:24], a[23:16], a[15:8], a[7:0],
            c[31:24], c[23:16], c[15:8], c[7:0]}, 8'h00);
  endtask
  // Accept each reply byte in turn; sum adds the zero-sum trailer
  task automatic expect_reply(input logic [7:0] q[$], input bit sum);
    if (sum) q.push_back(8'h00 - q.sum());
    foreach (q[i]) begin
      while (tx_valid_ff !== 1'b1) @(negedge sys_clk);
      cmp_count++;
      if (tx_data_ff !== q[i]) begin
        num_errors++;
        $display("Error tx_data_ff expected %h seen %h", q[i], tx_data_ff);
      end
      tx_ready = 1'b1;
      @(negedge sys_clk);
      tx_ready = 1'b0;
    end
  endtask
  task automatic t_select();
    fail = 1'b1;
    send(8'h48);
    expect_reply('{8'hc8, 8'h54}, 0);
    send(8'h4f);
    expect_reply('{8'h5f, 8'h02, 8'h3f, 8'h01}, 1);
    fail = 1'b0;
    send(8'h48);
    expect_reply('{8'h06}, 0);
  endtask
  task automatic t_erase();
    frame('{8'h58, 8'h01, 8'h0b}, 8'h00);
    expect_reply('{8'h06}, 0);
    frame('{8'h58, 8'h01, 8'h0c}, 8'h00);
    expect_reply('{8'hd8, 8'h29}, 0);
    frame('{8'h58, 8'h01, 8'h03}, 8'h01);
    expect_reply('{8'hd8, 8'h11}, 0);
    fail = 1'b1;
    frame('{8'h58, 8'h01, 8'h00}, 8'h00);
    expect_reply('{8'hd8, 8'h51}, 0);
    fail = 1'b0;
    send(8'h4f);
    expect_reply('{8'h5f, 8'h02, 8'h5f, 8'h01}, 1);
    frame('{8'h58, 8'h01, 8'hff}, 8'h00);
    expect_reply('{8'h06}, 0);
    frame('{8'h58, 8'h01, 8'h03}, 8'h00);
    expect_reply('{8'hd8, 8'h80}, 0);
  endtask
  task automatic t_read();
    rd(8'h01, 32'h0000_0010, 32'h0000_0002);
    expect_reply('{8'h52, 8'h00, 8'h00, 8'h00, 8'h02, 8'h11, 8'h10}, 1);
    rd(8'h02, 32'h0, 32'h1);
    expect_reply('{8'hd2, 8'h2a}, 0);
    rd(8'h00, 32'h0000_2000, 32'h1);
    expect_reply('{8'hd2, 8'h2a}, 0);
    rd(8'h01, 32'h0007_ffff, 32'h2);
    expect_reply('{8'hd2, 8'h2b}, 0);
  endtask
  // Boot area holds its low address byte, so the total is 32 x 0x7f80
  task automatic t_misc();
    send(8'h4a);
    expect_reply('{8'h5a, 8'h04, 8'h00, 8'h0f, 8'hf0, 8'h00}, 1);
    send(8'h4c);
    expect_reply('{8'hcc, 8'h52}, 0);
    send(8'h99);
    expect_reply('{8'h80}, 0);
  endtask
  initial begin
    {rx_data, rx_valid, tx_ready, fail} = '0;
    num_errors = 0;
    cmp_count = 0;
    rst_b = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    @(negedge sys_clk);
    t_select();
    t_erase();
    t_read();
    t_misc();
    end_of_test();
  end
  // Hang guard sized for two boot area scans of about 16k cycles each
  initial begin
    #700_000;
    num_errors++;
    end_of_test();
  end
endmodule // tb_top
